// ---- bench/hbridge_spi_control_logic_tb.sv ----
// self-checking bench for the h-bridge serial control logic
// assumes the host model drives the serial pins, the bench the rest
`timescale 1ns/1ps
module hbridge_spi_control_logic_tb
  import hbridge_pkg::*;
;
  logic mclk, resetn, sclk, csN, mosi, misoOut, misoOeN;
  logic dirInputA, dirInputB, sleepWakeInput, outputDisableInput;
  logic [15:0] faultStatus;
  logic faultFlagNOut, faultFlagNOeN, hsOnA, lsOnA, hsOnB, lsOnB;
  logic [2:0] slewSel;
  logic [1:0] currentLimitSel;
  logic sleepMode, standbyMode, rxValid;
  logic [31:0] rxWord;
  logic [31:0] expQ[$];
  logic [12:0] d;
  logic [15:0] w;
  int n_mismatch = 0, cmp_count = 0, runA = 0, runB = 0, gapA, gapB, g;

  hbridge_spi_control DUT (.mclk(mclk), .resetn(resetn), .sclk(sclk),
    .csN(csN), .mosi(mosi), .misoOut(misoOut), .misoOeN(misoOeN),
    .dirInputA(dirInputA), .dirInputB(dirInputB),
    .sleepWakeInput(sleepWakeInput),
    .outputDisableInput(outputDisableInput), .faultStatus(faultStatus),
    .faultFlagNOut(faultFlagNOut), .faultFlagNOeN(faultFlagNOeN),
    .hsOnA(hsOnA), .lsOnA(lsOnA), .hsOnB(hsOnB), .lsOnB(lsOnB),
    .slewSel(slewSel), .currentLimitSel(currentLimitSel),
    .sleepMode(sleepMode), .standbyMode(standbyMode));
  spi_host_model host (.mclk(mclk), .sclk(sclk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut), .misoOeN(misoOeN), .rxValid(rxValid),
    .rxWord(rxWord));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] e, g2);
    cmp_count++;
    if (g2 !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g2);
    end
  endtask
  task automatic frame(input logic [31:0] tx, input int n, e);
    expQ.push_back(e);
    host.xfer(tx, n);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // oldest expected word meets each finished frame
  always @(posedge mclk) begin
    if (rxValid) chk("miso word", expQ.pop_front(), rxWord);
  end
  // both-off run length just before a gate turns on is the dead gap
  always @(posedge mclk) begin
    if ((hsOnA && lsOnA) || (hsOnB && lsOnB)) chk("shoot", 0, 1);
    if (hsOnA || lsOnA) begin
      if (runA != 0) gapA = runA;
      runA = 0;
    end else runA++;
    if (hsOnB || lsOnB) begin
      if (runB != 0) gapB = runB;
      runB = 0;
    end else runB++;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    void'($urandom(29737));
    resetn = 1'b0;
    dirInputA = 1'b0;
    dirInputB = 1'b0;
    sleepWakeInput = 1'b0;
    outputDisableInput = 1'b0;
    faultStatus = '0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("reset", {misoOeN, faultFlagNOeN, sleepMode, standbyMode, hsOnA,
      lsOnA, hsOnB, lsOnB, slewSel, currentLimitSel, faultFlagNOut},
      14'h3800);
    $display("test reset done");
    d = 13'($urandom());
    w = 16'($urandom());
    g = 5 * (d[2:0] + 1);
    frame({1'b1, ADDR_CONFIG, d}, 16, 0);
    chk("config", {slewSel, currentLimitSel}, {d[2:0], d[4:3]});
    frame({w, 1'b0, ADDR_CONFIG, 13'h0}, 32, {3'h0, d, w});
    chk("miso release", misoOeN, 1);
    frame(32'h000000FF, 8, {3'h0, d[12:8]});
    chk("short frame", {slewSel, currentLimitSel}, {d[2:0], d[4:3]});
    frame({1'b1, ADDR_MASK, 13'h0}, 16, {3'h0, d});
    faultStatus <= 16'h0001;
    repeat (10) @(posedge mclk);
    chk("masked flag", faultFlagNOeN, 1);
    frame({1'b1, ADDR_MASK, 13'h1}, 16, 0);
    repeat (8) @(posedge mclk);
    chk("flag", faultFlagNOeN, 0);
    frame({1'b0, ADDR_FAULT, 13'h0}, 16, 16'h0001);
    frame({1'b0, ADDR_STATE, 13'h0}, 16, 16'h0001);
    $display("test serial done");
    sleepWakeInput <= 1'b1;
    dirInputA <= 1'b1;
    repeat (80) @(posedge mclk);
    chk("drive", {hsOnA, lsOnA, hsOnB, lsOnB, sleepMode, standbyMode},
      6'b100100);
    dirInputA <= 1'b0;
    dirInputB <= 1'b1;
    repeat (80) @(posedge mclk);
    chk("reverse", {hsOnA, lsOnA, hsOnB, lsOnB}, 4'b0110);
    chk("gap a", gapA >= g && gapA <= g + 2, 1);
    chk("gap b", gapB >= g && gapB <= g + 2, 1);
    outputDisableInput <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("standby", {hsOnA, lsOnA, hsOnB, lsOnB, sleepMode, standbyMode},
      6'b000001);
    outputDisableInput <= 1'b0;
    repeat (80) @(posedge mclk);
    chk("resume", {hsOnA, lsOnA, hsOnB, lsOnB}, 4'b0110);
    sleepWakeInput <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("sleep", {hsOnA, lsOnA, hsOnB, lsOnB, sleepMode, standbyMode},
      6'b000010);
    $display("test bridge done");
    faultStatus <= 16'h0000;
    frame({1'b0, ADDR_FAULT, 13'h0}, 16, 16'h0013);
    frame({1'b0, ADDR_STATE, 13'h0}, 16, 16'h0001);
    repeat (8) @(posedge mclk);
    chk("flag clear", faultFlagNOeN, 1);
    $display("test fault done");
    chk("queue empty", expQ.size(), 0);
    test_done();
  end
endmodule // hbridge_spi_control_logic_tb

// ---- bench/spi_host_model.sv ----
// host-side serial master model for the h-bridge control bench
// assumes the bench calls xfer; miso is trusted only while misoOeN is low
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk,
  output logic sclk,
  output logic csN,
  output logic mosi,
  input wire logic misoOut,
  input wire logic misoOeN,
  output logic rxValid,
  output logic [31:0] rxWord
);
  // 6 mclk per half period keeps well above the 4-cycle minimum
  localparam int HALF = 6;
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    mosi = 1'b0;
    rxValid = 1'b0;
    rxWord = '0;
  end
  // sclk idles high so the first edge inside a frame is a fall
  task automatic xfer(input logic [31:0] tx, input int n);
    logic [31:0] rx;
    rx = '0;
    @(posedge mclk);
    csN <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (HALF) @(posedge mclk);
      // a released miso is read as the inverse, never as a stale level
      rx[i] = misoOeN ? ~rx[i] : misoOut;
      sclk <= 1'b0;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
    end
    repeat (HALF) @(posedge mclk);
    csN <= 1'b1;
    mosi <= ~mosi;
    rxWord <= rx;
    rxValid <= 1'b1;
    @(posedge mclk);
    rxValid <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule // spi_host_model

// ---- verilog/bridge_gate.sv ----
// gate control for one half-bridge with break-before-make
// assumes enable and dir are already synchronous to clk
`timescale 1ns/1ps
module bridge_gate
  import hbridge_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic enable,
  input wire logic dir,
  input wire logic [5:0] deadCycles,
  output logic hsOn_r,
  output logic lsOn_r
);
  typedef enum logic [1:0] {OFF, HIGH, LOW, DEAD} gate_e;
  gate_e st_r, st_nxt, target;
  logic [5:0] cnt_r, cnt_nxt;

  always_comb begin
    target = !enable ? OFF : (dir ? HIGH : LOW);
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      OFF: begin
        // a side released by disable still waits out the gap
        if (cnt_r != 6'h00) begin
          cnt_nxt = cnt_r - 6'h01;
        end else begin
          st_nxt = target;
        end
      end
      HIGH, LOW: begin
        if (target == OFF) begin
          st_nxt = OFF;
          cnt_nxt = deadCycles - 6'h01;
        end else if (target != st_r) begin
          // both transistors off before the other one turns on
          st_nxt = DEAD;
          cnt_nxt = deadCycles - 6'h01;
        end
      end
      DEAD: begin
        if (target == OFF) begin
          st_nxt = OFF;
        end else if (cnt_r == 6'h00) begin
          st_nxt = target;
        end else begin
          cnt_nxt = cnt_r - 6'h01;
        end
      end
      default: st_nxt = OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_r <= OFF;
      cnt_r <= 6'h00;
      hsOn_r <= 1'b0;
      lsOn_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      hsOn_r <= (st_nxt == HIGH);
      lsOn_r <= (st_nxt == LOW);
    end
  end

  a_no_shoot_thru: assert property (@(posedge clk) disable iff (!rstN)
    !(hsOn_r && lsOn_r)) else $error("both transistors on");
  a_gap_after_hs: assert property (@(posedge clk) disable iff (!rstN)
    $fell(hsOn_r) |-> (!lsOn_r)[*5]) else $error("low side on too soon");
  a_gap_after_ls: assert property (@(posedge clk) disable iff (!rstN)
    $fell(lsOn_r) |-> (!hsOn_r)[*5]) else $error("high side on too soon");
  a_tristate_off: assert property (@(posedge clk) disable iff (!rstN)
    !enable |=> !hsOn_r && !lsOn_r) else $error("driven while disabled");
  a_follow_dir: assert property (@(posedge clk) disable iff (!rstN)
    enable && dir && !hsOn_r |-> ##[1:42] (hsOn_r || !enable || !dir))
    else $error("output did not follow direction input");
endmodule // bridge_gate

// ---- verilog/hbridge_pkg.sv ----
// constants shared by the h-bridge control logic
// assumes a single 25 MHz mclk domain; serial pins arrive asynchronously
package hbridge_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // least break-before-make gap at the fastest slew setting
  localparam int DEAD_TIME_NS = 200;
  localparam int DEAD_BASE_CYC =
    (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WORD_BITS = 16;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // command word layout
  localparam int WR_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 13;
  localparam int DATA_HI = 12;
  // register addresses
  localparam logic [1:0] ADDR_FAULT = 2'h0;
  localparam logic [1:0] ADDR_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [1:0] ADDR_STATE = 2'h3;
  // configuration fields
  localparam int SLEW_LO = 0;
  localparam int SLEW_HI = 2;
  localparam int ILIM_LO = 3;
  localparam int ILIM_HI = 4;
  // values after reset
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;
  localparam logic [1:0] PREV_ADDR_RESET = 2'h0;
  // synchroniser bit positions
  localparam int SY_SCLK = 0;
  localparam int SY_CS = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_DIRA = 3;
  localparam int SY_DIRB = 4;
  localparam int SY_WAKE = 5;
  localparam int SY_DIS = 6;
  localparam int SY_FAULT = 7;
  localparam int SYNC_W = 23;
endpackage

// ---- verilog/hbridge_spi_control.sv ----
// serial slave, configuration store and output steering of the driver
// assumes sclk well below mclk/8 so that synchronised edges are seen
`timescale 1ns/1ps
// Functional notes
// - never both transistors of one half-bridge on together
// - slew time follows the slew field of the configuration register
// - each direction input chooses whether its high side or its low side is on
// - direction change passes through a dead gap, no shoot-through
// - wake input low: all four drivers off, sleep state
// - wake input high: leave sleep, normal function
// - disable input high while wake is high: drivers off, standby, not sleep
// - disable input low does not by itself block the outputs
// - slave only, daisy-chainable on one shared chip select
// - sample mosi on sclk fall, change miso on sclk rise
// - words shift out most significant bit first
// - after the 16 status bits, echo mosi bits until chip select rises
// - miso high impedance while chip select high
// - chip select rise commits the shift register as the command
// - chip select fall loads the previously addressed register
// - fault flag pulled low only for faults the mask selects
// - first direction input drives first output, second the second
module hbridge_spi_control
  import hbridge_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOeN,
  input wire logic dirInputA,
  input wire logic dirInputB,
  input wire logic sleepWakeInput,
  input wire logic outputDisableInput,
  input wire logic [15:0] faultStatus,
  output logic faultFlagNOut,
  output logic faultFlagNOeN,
  output logic hsOnA,
  output logic lsOnA,
  output logic hsOnB,
  output logic lsOnB,
  output logic [2:0] slewSel,
  output logic [1:0] currentLimitSel,
  output logic sleepMode,
  output logic standbyMode
);
  logic [SYNC_W-1:0] syncIn, syncOut;
  logic sclkS, csS, mosiS, dirAS, dirBS, wakeS, disS;
  logic [15:0] faultS;
  logic sclkD_r, csD_r;
  logic sclkFall, sclkRise, csFall, csRise;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic miso_r, miso_nxt;
  logic misoOeN_r, misoOeN_nxt;
  logic [1:0] prevAddr_r, prevAddr_nxt;
  logic [1:0] rdAddr_r, rdAddr_nxt;
  logic [15:0] config_r, config_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [15:0] faultLatch_r, faultLatch_nxt;
  logic [15:0] faultCap_r, faultCap_nxt;
  logic faultOeN_r, faultOeN_nxt;
  logic faultLow_r;
  logic sleep_r, sleep_nxt;
  logic standby_r, standby_nxt;
  logic [2:0] slew_r;
  logic [1:0] ilim_r;
  logic bridgeEnable;
  logic [5:0] deadCycles;
  logic commitOk;

  // address field of a command word
  function automatic logic [1:0] addrOf(input logic [15:0] w);
    addrOf = w[ADDR_HI:ADDR_LO];
  endfunction

  // gap scales with the slew setting so slow edges finish first
  function automatic logic [5:0] deadCount(input logic [2:0] s);
    deadCount = 6'(DEAD_BASE_CYC) * ({3'h0, s} + 6'h01);
  endfunction

  // word presented for the addressed register
  function automatic logic [15:0] readMux(
    input logic [1:0] a,
    input logic [15:0] flt,
    input logic [15:0] cfg,
    input logic [15:0] msk,
    input logic [4:0] st
  );
    case (a)
      ADDR_FAULT: readMux = flt;
      ADDR_CONFIG: readMux = cfg;
      ADDR_MASK: readMux = msk;
      default: readMux = {11'h000, st};
    endcase
  endfunction

  // select and clock enter inverted so a cleared synchroniser reads
  // their idle high level and no false edge follows reset
  assign syncIn = {faultStatus, outputDisableInput, sleepWakeInput,
                   dirInputB, dirInputA, mosi, ~csN, ~sclk};

  sync2 #(.W(SYNC_W)) u_sync (
    .clk(mclk),
    .rstN(resetn),
    .d(syncIn),
    .q(syncOut)
  );

  assign sclkS = !syncOut[SY_SCLK];
  assign csS = !syncOut[SY_CS];
  assign mosiS = syncOut[SY_MOSI];
  assign dirAS = syncOut[SY_DIRA];
  assign dirBS = syncOut[SY_DIRB];
  assign wakeS = syncOut[SY_WAKE];
  assign disS = syncOut[SY_DIS];
  assign faultS = syncOut[SY_FAULT +: 16];

  // edges are taken from the synchronised copies only
  assign sclkFall = sclkD_r && !sclkS;
  assign sclkRise = !sclkD_r && sclkS;
  assign csFall = csD_r && !csS;
  assign csRise = !csD_r && csS;
  // a frame shorter than one word is ignored on commit
  assign commitOk = csRise && (cnt_r == FRAME_BITS);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclkD_r <= 1'b1;
      csD_r <= 1'b1;
    end else begin
      sclkD_r <= sclkS;
      csD_r <= csS;
    end
  end

  // serial slave: one shift register serves status out and echo
  always_comb begin
    logic [15:0] loadWord;
    loadWord = readMux(prevAddr_r, faultLatch_r, config_r, mask_r,
                       {sleep_r, standby_r, dirAS, dirBS, !faultOeN_r});
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    miso_nxt = miso_r;
    rdAddr_nxt = rdAddr_r;
    faultCap_nxt = faultCap_r;
    misoOeN_nxt = csS;
    if (csFall) begin
      shift_nxt = loadWord;
      cnt_nxt = 5'h00;
      miso_nxt = loadWord[WORD_BITS-1];
      rdAddr_nxt = prevAddr_r;
      faultCap_nxt = faultLatch_r;
    end else if (!csS) begin
      if (sclkFall) begin
        // received bits move toward the top and leave in order
        shift_nxt = {shift_r[14:0], mosiS};
        if (cnt_r != FRAME_BITS) begin
          cnt_nxt = cnt_r + 5'h01;
        end
      end
      if (sclkRise) begin
        miso_nxt = shift_r[WORD_BITS-1];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= 16'h0000;
      cnt_r <= 5'h00;
      miso_r <= 1'b0;
      misoOeN_r <= 1'b1;
      rdAddr_r <= PREV_ADDR_RESET;
      faultCap_r <= 16'h0000;
    end else begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      miso_r <= miso_nxt;
      misoOeN_r <= misoOeN_nxt;
      rdAddr_r <= rdAddr_nxt;
      faultCap_r <= faultCap_nxt;
    end
  end

  // command commit and register store
  always_comb begin
    logic [15:0] clr;
    clr = 16'h0000;
    prevAddr_nxt = prevAddr_r;
    config_nxt = config_r;
    mask_nxt = mask_r;
    if (commitOk) begin
      prevAddr_nxt = addrOf(shift_r);
      if (shift_r[WR_BIT]) begin
        case (addrOf(shift_r))
          ADDR_CONFIG: config_nxt = {3'h0, shift_r[DATA_HI:0]};
          ADDR_MASK: mask_nxt = {3'h0, shift_r[DATA_HI:0]};
          default: config_nxt = config_r;
        endcase
      end
      if (rdAddr_r == ADDR_FAULT) begin
        clr = faultCap_r;
      end
    end
    // a fault present now survives its own clear
    faultLatch_nxt = (faultLatch_r & ~clr) | faultS;
    faultOeN_nxt = ~|(faultLatch_r & mask_r);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prevAddr_r <= PREV_ADDR_RESET;
      config_r <= CONFIG_RESET;
      mask_r <= MASK_RESET;
      faultLatch_r <= 16'h0000;
      faultOeN_r <= 1'b1;
      faultLow_r <= 1'b0;
    end else begin
      prevAddr_r <= prevAddr_nxt;
      config_r <= config_nxt;
      mask_r <= mask_nxt;
      faultLatch_r <= faultLatch_nxt;
      faultOeN_r <= faultOeN_nxt;
      faultLow_r <= 1'b0;
    end
  end

  // power modes and drive enable
  always_comb begin
    sleep_nxt = !wakeS;
    standby_nxt = wakeS && disS;
    // disable low only removes its own block, wake still governs
    bridgeEnable = wakeS && !disS;
    deadCycles = deadCount(config_r[SLEW_HI:SLEW_LO]);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sleep_r <= 1'b1;
      standby_r <= 1'b0;
      slew_r <= CONFIG_RESET[SLEW_HI:SLEW_LO];
      ilim_r <= CONFIG_RESET[ILIM_HI:ILIM_LO];
    end else begin
      sleep_r <= sleep_nxt;
      standby_r <= standby_nxt;
      slew_r <= config_r[SLEW_HI:SLEW_LO];
      ilim_r <= config_r[ILIM_HI:ILIM_LO];
    end
  end

  // each direction input steers its own half-bridge
  bridge_gate u_gate_a (
    .clk(mclk),
    .rstN(resetn),
    .enable(bridgeEnable),
    .dir(dirAS),
    .deadCycles(deadCycles),
    .hsOn_r(hsOnA),
    .lsOn_r(lsOnA)
  );

  bridge_gate u_gate_b (
    .clk(mclk),
    .rstN(resetn),
    .enable(bridgeEnable),
    .dir(dirBS),
    .deadCycles(deadCycles),
    .hsOn_r(hsOnB),
    .lsOn_r(lsOnB)
  );

  // miso is a plain push-pull pin gated by its enable
  assign misoOut = miso_r;
  assign misoOeN = misoOeN_r;
  // open drain: the pin only ever pulls low
  assign faultFlagNOut = faultLow_r;
  assign faultFlagNOeN = faultOeN_r;
  assign slewSel = slew_r;
  assign currentLimitSel = ilim_r;
  assign sleepMode = sleep_r;
  assign standbyMode = standby_r;

  a_miso_hiz: assert property (@(posedge mclk) disable iff (!resetn)
    csS ##1 csS |-> misoOeN_r) else $error("miso driven while deselected");
  a_miso_msb: assert property (@(posedge mclk) disable iff (!resetn)
    csFall |=> (misoOut == shift_r[WORD_BITS-1]) && !misoOeN_r)
    else $error("first bit is not the loaded msb");
  a_echo_bit: assert property (@(posedge mclk) disable iff (!resetn)
    !csS && !csFall && sclkRise && (cnt_r == FRAME_BITS)
    |=> (misoOut == shift_r[WORD_BITS-1]) && !misoOeN_r)
    else $error("echo path broken");
  a_commit_cfg: assert property (@(posedge mclk) disable iff (!resetn)
    commitOk && shift_r[WR_BIT] && (addrOf(shift_r) == ADDR_CONFIG)
    |=> config_r == {3'h0, $past(shift_r[DATA_HI:0])})
    else $error("configuration not committed");
  a_short_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    csRise && (cnt_r != FRAME_BITS) |=> $stable(config_r) && $stable(mask_r))
    else $error("short frame changed a register");
  a_fault_flag: assert property (@(posedge mclk) disable iff (!resetn)
    |(faultS & mask_r) |-> ##[1:2] !faultFlagNOeN)
    else $error("masked-in fault not flagged");
  a_fault_masked: assert property (@(posedge mclk) disable iff (!resetn)
    ((faultLatch_r & mask_r) == 16'h0000) |=> faultFlagNOeN)
    else $error("fault flag without selected fault");
  a_sleep_off: assert property (@(posedge mclk) disable iff (!resetn)
    !wakeS |-> ##[1:2] (sleepMode && !hsOnA && !lsOnA && !hsOnB && !lsOnB))
    else $error("drivers on in sleep");
  a_standby: assert property (@(posedge mclk) disable iff (!resetn)
    wakeS && disS |=> standbyMode && !sleepMode)
    else $error("disable did not give standby");
  a_wake_on: assert property (@(posedge mclk) disable iff (!resetn)
    wakeS |=> !sleepMode) else $error("awake but still asleep");
  a_disable_off: assert property (@(posedge mclk) disable iff (!resetn)
    disS |=> !hsOnA && !lsOnA && !hsOnB && !lsOnB)
    else $error("drivers on while disabled");
  a_slew_follow: assert property (@(posedge mclk) disable iff (!resetn)
    $stable(config_r) ##1 $stable(config_r)
    |-> (slewSel == config_r[SLEW_HI:SLEW_LO]))
    else $error("slew output does not follow configuration");
  a_mask_commit: assert property (@(posedge mclk) disable iff (!resetn)
    commitOk && shift_r[WR_BIT] && (addrOf(shift_r) == ADDR_MASK)
    |=> mask_r == {3'h0, shift_r[DATA_HI:0]})
    else $error("mask not committed");
  a_short_ptr: assert property (@(posedge mclk) disable iff (!resetn)
    csRise && (cnt_r != FRAME_BITS) |=> $stable(prevAddr_r))
    else $error("short frame moved the read pointer");
  a_load_cfg: assert property (@(posedge mclk) disable iff (!resetn)
    csFall && (prevAddr_r == ADDR_CONFIG) |=> shift_r == config_r)
    else $error("configuration not loaded on select");
  a_flag_low: assert property (@(posedge mclk) disable iff (!resetn)
    faultFlagNOut == 1'b0) else $error("open-drain flag drives high");

  c_cfg_write: cover property (@(posedge mclk) disable iff (!resetn)
    commitOk && shift_r[WR_BIT] && (addrOf(shift_r) == ADDR_CONFIG));
  c_fault_low: cover property (@(posedge mclk) disable iff (!resetn)
    $fell(faultFlagNOeN));
  c_dir_swap: cover property (@(posedge mclk) disable iff (!resetn)
    $fell(hsOnA) ##[1:45] lsOnA);
  c_echo: cover property (@(posedge mclk) disable iff (!resetn)
    !csS && sclkRise && (cnt_r == FRAME_BITS));
  c_short_frame: cover property (@(posedge mclk) disable iff (!resetn)
    csRise && (cnt_r != FRAME_BITS));
endmodule // hbridge_spi_control

// ---- verilog/sync2.sv ----
// two flip-flop synchroniser, one chain per bit
// assumes the inputs are asynchronous to clk; only q may be read
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule // sync2
